// File: hdl/acs_pkg.sv
// Package: register map, command codes, field positions and timing for the axis counter block
package acs_pkg;

  // ----------------------------------------------------------------
  // APB register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_COMMAND = 8'h00;
  localparam logic [7:0] ADDR_ENV1 = 8'h04;
  localparam logic [7:0] ADDR_ENV2 = 8'h08;
  localparam logic [7:0] ADDR_ENV3 = 8'h0C;
  localparam logic [7:0] ADDR_STOP_CAUSE = 8'h10;
  localparam logic [7:0] ADDR_SPEED_STATUS = 8'h14;
  localparam logic [7:0] ADDR_CMD_POS = 8'h18;
  localparam logic [7:0] ADDR_MECH_POS = 8'h1C;
  localparam logic [7:0] ADDR_DEFL = 8'h20;
  localparam logic [7:0] ADDR_GP = 8'h24;
  localparam logic [7:0] ADDR_AXIS_CTRL = 8'h28;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_POS_CLEAR = 8'h20;
  localparam logic [7:0] CMD_MECH_CLEAR = 8'h21;
  localparam logic [7:0] CMD_DEFL_CLEAR = 8'h22;
  localparam logic [7:0] CMD_GP_CLEAR = 8'h23;
  localparam logic [7:0] CMD_DEV_ASSERT = 8'h24;
  localparam logic [7:0] CMD_DEV_RELEASE = 8'h25;

  // ----------------------------------------------------------------
  // Environment-1 field positions
  // ----------------------------------------------------------------
  localparam int ENV1_LIMIT_MODE = 3;
  localparam int ENV1_DEV_AUTO = 10;
  localparam int ENV1_DEV_HOME = 11;
  localparam int ENV1_DEV_PW_LO = 12;
  localparam int ENV1_DEV_POL = 15;
  localparam int ENV1_DIR_DLY_OFF = 28;

  // ----------------------------------------------------------------
  // Environment-2 / environment-3 field positions
  // ----------------------------------------------------------------
  localparam int ENV2_ENC_FILTER = 18;
  localparam int ENV2_ENC_MODE_LO = 20;
  localparam int ENV2_ENC_DIR_INV = 22;
  localparam int ENV3_DEFL_CLR_IN = 18;
  localparam int ENV3_GP_CLR_IN = 19;
  localparam int ENV3_DEFL_CLR_HOME = 22;
  localparam int ENV3_GP_CLR_HOME = 23;
  localparam int ENV3_GP_BACKLASH = 27;
  localparam int ENV3_DEFL_HALT = 30;
  localparam int ENV3_GP_HALT = 31;

  // ----------------------------------------------------------------
  // Stop-cause bits and speed-status field
  // ----------------------------------------------------------------
  localparam int STOP_CMP_LO = 0;
  localparam int STOP_ALARM = 7;
  localparam int STOP_EMERG = 9;
  localparam int STOP_BAD_DATA = 12;
  localparam int STOP_PARTNER = 13;
  localparam int STOP_OVERRANGE = 15;
  localparam int STOP_ENC_ERR = 16;
  localparam int SPD_ZCOUNT_LO = 16;

  // ----------------------------------------------------------------
  // Reset values, widths and timing
  // ----------------------------------------------------------------
  localparam logic [31:0] ENV_RESET = 32'h0000_0000;
  localparam int DEFL_WIDTH = 16;
  localparam int GP_WIDTH = 28;
  localparam int POS_WIDTH = 28;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int DIR_DELAY_PS = 200_000_000;
  localparam int DIR_DELAY_CYC = DIR_DELAY_PS / CLK_PERIOD_PS;
  localparam int DEV_PW_BASE_CYC = 2000;
  localparam int FILTER_CYC = 3;

  // ----------------------------------------------------------------
  // Carrier and state types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cmd_up;
    logic cmd_dn;
    logic corr_pulse;
    logic home_done;
  } acs_motion_t;

  typedef struct packed {
    logic [4:0] cmp_stop;
    logic bad_data;
    logic partner_stop;
  } acs_stop_t;

  typedef enum logic [1:0] {
    DIR_IDLE,
    DIR_WAIT
  } acs_dir_state_t;

endpackage

// File: hdl/acs_axis.sv
// Axis counters, deviation-clear output, encoder input and stop-cause status
module acs_axis
  import acs_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Axis pins
  input wire logic i_counter_clear_input,
  input wire logic i_end_limit_input,
  input wire logic i_servo_alarm_input,
  input wire logic i_emergency_stop_input,
  input wire logic i_encoder_phase_a,
  input wire logic i_encoder_phase_b,
  input wire logic i_encoder_phase_z,
  // Motion core handshake
  input wire acs_motion_t i_motion,
  input wire acs_stop_t i_stop,
  input wire logic i_homing,
  output logic o_deviation_clear_output,
  output logic o_pulse_enable,
  output logic o_decel_stop,
  output logic o_dir
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] env1, env2, env3, next_env1, next_env2, next_env3;
  logic [31:0] stop_cause, next_stop_cause;
  logic [POS_WIDTH-1:0] cmd_pos, next_cmd_pos, mech_pos, next_mech_pos;
  logic [DEFL_WIDTH-1:0] defl, next_defl;
  logic [GP_WIDTH-1:0] gp, next_gp;
  logic [3:0] zcount, next_zcount;
  logic [2:0] a_hist, b_hist, next_a_hist, next_b_hist;
  logic a_f, b_f, next_a_f, next_b_f, a_d, b_d, z_d, clr_d;
  logic [18:0] dev_cnt, next_dev_cnt;
  logic dev_on, next_dev_on;
  logic dev_level, next_dev_level;
  logic [15:0] dir_cnt, next_dir_cnt;
  acs_dir_state_t dir_st, next_dir_st;
  logic dir, next_dir, pulse_en, next_pulse_en, decel, next_decel;
  logic [31:0] prdata, next_prdata;
  logic pslverr, next_pslverr, pready, next_pready;

  // Access decode helpers; writes land at the completion edge, when the master sees pready
  logic acc_take, wr_acc, rd_acc, cmd_wr;
  logic [7:0] cmd;
  assign acc_take = i_psel && i_penable && !pready;
  assign wr_acc = i_psel && i_penable && i_pwrite && pready && !pslverr;
  assign rd_acc = acc_take && !i_pwrite;
  assign cmd_wr = wr_acc && (i_paddr == ADDR_COMMAND);
  assign cmd = i_pwdata[7:0];

  // Known register address check, shared by read and write decode
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a <= ADDR_AXIS_CTRL) && (a[1:0] == 2'b00);
  endfunction

  // Quadrature step: +1, -1 or 0 from old/new phase pairs
  function automatic logic [1:0] quad_step(input logic [1:0] o, input logic [1:0] n);
    logic [3:0] k;
    k = {o, n};
    case (k)
      4'h1, 4'h7, 4'hE, 4'h8: quad_step = 2'b01;
      4'h2, 4'hB, 4'hD, 4'h4: quad_step = 2'b11;
      default: quad_step = 2'b00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Encoder input conditioning
  // ----------------------------------------------------------------
  logic ea, eb, enc_up, enc_dn, enc_err;
  logic [1:0] stp;
  always_comb begin
    // Filter needs three equal samples; trades latency for glitch immunity
    next_a_hist = {a_hist[1:0], i_encoder_phase_a};
    next_b_hist = {b_hist[1:0], i_encoder_phase_b};
    next_a_f = (&a_hist) ? 1'b1 : ((|a_hist) ? a_f : 1'b0);
    next_b_f = (&b_hist) ? 1'b1 : ((|b_hist) ? b_f : 1'b0);
    ea = env2[ENV2_ENC_FILTER] ? a_f : i_encoder_phase_a;
    eb = env2[ENV2_ENC_FILTER] ? b_f : i_encoder_phase_b;
    stp = quad_step({a_d, b_d}, {ea, eb});
    enc_err = (a_d != ea) && (b_d != eb); // Both phases moved at once
    enc_up = 1'b0;
    enc_dn = 1'b0;
    case (env2[ENV2_ENC_MODE_LO +: 2])
      2'd0: begin // x1: A rising only
        enc_up = ea && !a_d && !eb;
        enc_dn = ea && !a_d && eb;
      end
      2'd1: begin // x2: both A edges
        enc_up = (ea != a_d) && (ea != eb);
        enc_dn = (ea != a_d) && (ea == eb);
      end
      2'd2: begin // x4
        enc_up = stp == 2'b01;
        enc_dn = stp == 2'b11;
      end
      default: begin // Up/down pulse inputs
        enc_up = ea && !a_d;
        enc_dn = eb && !b_d;
      end
    endcase
    if (env2[ENV2_ENC_DIR_INV]) begin
      {enc_up, enc_dn} = {enc_dn, enc_up};
    end
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  logic clr_edge, z_edge, over;
  always_comb begin
    clr_edge = i_counter_clear_input && !clr_d;
    z_edge = i_encoder_phase_z && !z_d;
    next_cmd_pos = cmd_pos + POS_WIDTH'(i_motion.cmd_up) - POS_WIDTH'(i_motion.cmd_dn);
    next_mech_pos = mech_pos + POS_WIDTH'(enc_up) - POS_WIDTH'(enc_dn);
    over = (cmd_pos == {POS_WIDTH{1'b1}} && i_motion.cmd_up)
        || (cmd_pos == '0 && i_motion.cmd_dn);
    next_defl = defl;
    if (!env3[ENV3_DEFL_HALT]) begin
      next_defl = defl + DEFL_WIDTH'(i_motion.cmd_up) - DEFL_WIDTH'(i_motion.cmd_dn)
                - DEFL_WIDTH'(enc_up) + DEFL_WIDTH'(enc_dn);
    end
    next_gp = gp;
    if (!env3[ENV3_GP_HALT] && (!i_motion.corr_pulse || env3[ENV3_GP_BACKLASH])) begin
      next_gp = gp + GP_WIDTH'(i_motion.cmd_up || i_motion.cmd_dn);
    end
    next_zcount = zcount;
    if (!i_homing) begin
      next_zcount = '0;
    end else if (z_edge && zcount != 4'hF) begin
      next_zcount = zcount + 4'h1;
    end
    // Zero loads take priority over counting
    if (cmd_wr && cmd == CMD_POS_CLEAR) next_cmd_pos = '0;
    if (cmd_wr && cmd == CMD_MECH_CLEAR) next_mech_pos = '0;
    if ((cmd_wr && cmd == CMD_DEFL_CLEAR)
        || (clr_edge && env3[ENV3_DEFL_CLR_IN])
        || (i_motion.home_done && env3[ENV3_DEFL_CLR_HOME])) begin
      next_defl = '0;
    end
    if ((cmd_wr && cmd == CMD_GP_CLEAR)
        || (clr_edge && env3[ENV3_GP_CLR_IN])
        || (i_motion.home_done && env3[ENV3_GP_CLR_HOME])) begin
      next_gp = '0;
    end
  end

  // ----------------------------------------------------------------
  // Deviation-clear output
  // ----------------------------------------------------------------
  logic dev_fire;
  always_comb begin
    next_dev_on = dev_on;
    next_dev_cnt = dev_cnt;
    next_dev_level = dev_level;
    dev_fire = (cmd_wr && cmd == CMD_DEV_ASSERT)
        || (env1[ENV1_DEV_AUTO] && i_end_limit_input)
        || (env1[ENV1_DEV_HOME] && i_motion.home_done);
    if (dev_on && !dev_level && dev_cnt != '0) begin
      next_dev_cnt = dev_cnt - 19'd1;
      if (dev_cnt == 19'd1) next_dev_on = 1'b0;
    end
    if (dev_fire) begin
      next_dev_on = 1'b1;
      // Width code 7 is level mode; others scale the base width by 2^code
      next_dev_level = env1[ENV1_DEV_PW_LO +: 3] == 3'd7;
      next_dev_cnt = 19'(DEV_PW_BASE_CYC) << env1[ENV1_DEV_PW_LO +: 3];
    end else if (cmd_wr && cmd == CMD_DEV_RELEASE && dev_level) begin
      next_dev_on = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Limit stop and direction-change timer
  // ----------------------------------------------------------------
  logic want_dir;
  always_comb begin
    want_dir = i_motion.cmd_dn ? 1'b1 : (i_motion.cmd_up ? 1'b0 : dir);
    next_pulse_en = pulse_en;
    next_decel = 1'b0;
    next_dir = dir;
    next_dir_st = dir_st;
    next_dir_cnt = dir_cnt;
    // Limit reaction chosen by mode bit
    if (i_end_limit_input && env1[ENV1_LIMIT_MODE]) next_decel = 1'b1;
    case (dir_st)
      DIR_IDLE: begin
        next_pulse_en = !(i_end_limit_input && !env1[ENV1_LIMIT_MODE]);
        if (want_dir != dir) begin
          next_dir = want_dir;
          if (!env1[ENV1_DIR_DLY_OFF]) begin
            next_dir_st = DIR_WAIT;
            next_dir_cnt = 16'(DIR_DELAY_CYC - 1);
            next_pulse_en = 1'b0;
          end
        end
      end
      DIR_WAIT: begin
        next_pulse_en = 1'b0;
        next_dir_cnt = dir_cnt - 16'd1;
        if (dir_cnt == '0) next_dir_st = DIR_IDLE;
      end
      default: next_dir_st = DIR_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Stop-cause status: hardware set wins over software clear
  // ----------------------------------------------------------------
  always_comb begin
    next_stop_cause = stop_cause;
    if (wr_acc && i_paddr == ADDR_STOP_CAUSE) next_stop_cause = stop_cause & ~i_pwdata;
    next_stop_cause[STOP_CMP_LO +: 5] = next_stop_cause[STOP_CMP_LO +: 5] | i_stop.cmp_stop;
    if (i_servo_alarm_input) next_stop_cause[STOP_ALARM] = 1'b1;
    if (i_emergency_stop_input) next_stop_cause[STOP_EMERG] = 1'b1;
    if (i_stop.bad_data) next_stop_cause[STOP_BAD_DATA] = 1'b1;
    if (i_stop.partner_stop) next_stop_cause[STOP_PARTNER] = 1'b1;
    if (over) next_stop_cause[STOP_OVERRANGE] = 1'b1;
    if (enc_err) next_stop_cause[STOP_ENC_ERR] = 1'b1;
  end

  // ----------------------------------------------------------------
  // APB slave: one wait state, error on unmapped address
  // ----------------------------------------------------------------
  always_comb begin
    next_env1 = env1;
    next_env2 = env2;
    next_env3 = env3;
    next_prdata = prdata;
    next_pready = acc_take;
    next_pslverr = acc_take && !addr_known(i_paddr);
    if (wr_acc && i_paddr == ADDR_ENV1) next_env1 = i_pwdata;
    if (wr_acc && i_paddr == ADDR_ENV2) next_env2 = i_pwdata;
    if (wr_acc && i_paddr == ADDR_ENV3) next_env3 = i_pwdata;
    if (rd_acc) begin
      case (i_paddr)
        ADDR_ENV1: next_prdata = env1;
        ADDR_ENV2: next_prdata = env2;
        ADDR_ENV3: next_prdata = env3;
        ADDR_STOP_CAUSE: next_prdata = stop_cause;
        ADDR_SPEED_STATUS: next_prdata = 32'(zcount) << SPD_ZCOUNT_LO;
        ADDR_CMD_POS: next_prdata = 32'(cmd_pos);
        ADDR_MECH_POS: next_prdata = 32'(mech_pos);
        ADDR_DEFL: next_prdata = 32'(defl);
        ADDR_GP: next_prdata = 32'(gp);
        ADDR_AXIS_CTRL: next_prdata = {29'h0, dir, dev_on, pulse_en};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      env1 <= ENV_RESET;
      env2 <= ENV_RESET;
      env3 <= ENV_RESET;
      stop_cause <= '0;
      cmd_pos <= '0;
      mech_pos <= '0;
      defl <= '0;
      gp <= '0;
      zcount <= '0;
      a_hist <= '0;
      b_hist <= '0;
      a_f <= 1'b0;
      b_f <= 1'b0;
      a_d <= 1'b0;
      b_d <= 1'b0;
      z_d <= 1'b0;
      clr_d <= 1'b0;
      dev_on <= 1'b0;
      dev_cnt <= '0;
      dev_level <= 1'b0;
      dir_st <= DIR_IDLE;
      dir_cnt <= '0;
      dir <= 1'b0;
      pulse_en <= 1'b0;
      decel <= 1'b0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      o_deviation_clear_output <= 1'b1; // Inactive level of the reset polarity
    end else if (i_ce) begin
      env1 <= next_env1;
      env2 <= next_env2;
      env3 <= next_env3;
      stop_cause <= next_stop_cause;
      cmd_pos <= next_cmd_pos;
      mech_pos <= next_mech_pos;
      defl <= next_defl;
      gp <= next_gp;
      zcount <= next_zcount;
      a_hist <= next_a_hist;
      b_hist <= next_b_hist;
      a_f <= next_a_f;
      b_f <= next_b_f;
      a_d <= ea;
      b_d <= eb;
      z_d <= i_encoder_phase_z;
      clr_d <= i_counter_clear_input;
      dev_on <= next_dev_on;
      dev_cnt <= next_dev_cnt;
      dev_level <= next_dev_level;
      dir_st <= next_dir_st;
      dir_cnt <= next_dir_cnt;
      dir <= next_dir;
      pulse_en <= next_pulse_en;
      decel <= next_decel;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      o_deviation_clear_output <= next_dev_on ~^ next_env1[ENV1_DEV_POL];
    end
  end

  assign o_prdata = prdata;
  assign o_pready = pready;
  assign o_pslverr = pslverr;
  assign o_pulse_enable = pulse_en;
  assign o_decel_stop = decel;
  assign o_dir = dir;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_defl_cmd_clear: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && cmd_wr && cmd == CMD_DEFL_CLEAR |=> defl == '0)
    else $error("deflection counter not cleared by command");
  chk_pos_cmd_clear: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && cmd_wr && cmd == CMD_POS_CLEAR |=> cmd_pos == '0)
    else $error("command position not cleared");
  chk_gp_halt_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && env3[ENV3_GP_HALT] && !(cmd_wr && cmd == CMD_GP_CLEAR) && !clr_edge
    && !i_motion.home_done |=> $stable(gp))
    else $error("general counter moved while halted");
  chk_limit_immediate: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && i_end_limit_input && !env1[ENV1_LIMIT_MODE] |=> !pulse_en)
    else $error("pulse output not stopped on limit");
  chk_dev_polarity: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_deviation_clear_output == (dev_on ~^ env1[ENV1_DEV_POL]))
    else $error("deviation clear polarity wrong");
  chk_dev_assert_cmd: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && cmd_wr && cmd == CMD_DEV_ASSERT |=> dev_on)
    else $error("deviation clear not asserted by command");
  chk_dir_delay_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && dir_st == DIR_IDLE && want_dir != dir && !env1[ENV1_DIR_DLY_OFF]
    |=> !pulse_en [*2])
    else $error("direction delay not applied");
  chk_alarm_flag: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && i_servo_alarm_input |=> stop_cause[STOP_ALARM])
    else $error("servo alarm flag not set");

endmodule

// File: dv/acs_axis_partner.sv
// Partner model: motion core and encoder as seen from the axis block
module acs_axis_partner
  import acs_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Pulses and encoder phases toward the block
  output acs_motion_t o_motion,
  output logic o_enc_a,
  output logic o_enc_b
);
  // ----------------------------------------
  // Idle: encoder phases low, no pulses
  // ----------------------------------------
  initial begin
    o_motion = '0;
    o_enc_a = 1'b0;
    o_enc_b = 1'b0;
  end

  // Gap between pulses so each is its own event
  task automatic issue(input int n, input logic corr, input logic home);
    repeat (n) begin
      @(posedge i_clk);
      o_motion <= '{cmd_up: !home, cmd_dn: 1'b0, corr_pulse: corr, home_done: home};
      @(posedge i_clk);
      o_motion <= '0;
    end
  endtask

  // Down pulses, one idle cycle between them
  task automatic issue_dn(input int n);
    repeat (n) begin
      @(posedge i_clk);
      o_motion <= '{cmd_up: 1'b0, cmd_dn: 1'b1, corr_pulse: 1'b0, home_done: 1'b0};
      @(posedge i_clk);
      o_motion <= '0;
    end
  endtask

  // One-cycle high pulses on phase A only
  task automatic pulse_a(input int n);
    repeat (n) begin
      @(posedge i_clk);
      o_enc_a <= 1'b1;
      @(posedge i_clk);
      o_enc_a <= 1'b0;
    end
  endtask

  // Both phases move at once: an illegal quadrature step
  task automatic glitch();
    @(posedge i_clk);
    o_enc_a <= ~o_enc_a;
    o_enc_b <= ~o_enc_b;
  endtask
endmodule

// File: dv/acs_axis_tb_top.sv
// Testbench: register-level tests of the axis counter block
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module acs_axis_tb_top
  import acs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic resetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic clr, lim, servo_alarm_input, emg, homing, dev, pen, dec, ez, mdir;
  acs_stop_t stp;
  acs_motion_t mot;
  logic ea, eb;
  int n_fail = 0;
  int compares = 0;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  acs_axis_partner u_acs_axis_partner (.i_clk(clk), .o_motion(mot), .o_enc_a(ea), .o_enc_b(eb));

  acs_axis u_acs_axis (
    .i_clk(clk), .i_resetn(resetn), .i_ce(1'b1),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_counter_clear_input(clr), .i_end_limit_input(lim), .i_servo_alarm_input(servo_alarm_input),
    .i_emergency_stop_input(emg), .i_encoder_phase_a(ea), .i_encoder_phase_b(eb),
    .i_encoder_phase_z(ez), .i_motion(mot), .i_stop(stp), .i_homing(homing),
    .o_deviation_clear_output(dev), .o_pulse_enable(pen), .o_decel_stop(dec), .o_dir(mdir)
  );

  // ----------------------------------------
  // Verdict
  // ----------------------------------------
  task automatic close_out();
    $display("counts: compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // APB cycle; held until pready is seen, bounded wait
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      n_fail++;
      close_out();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    `CHK(rdat, e)
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    {psel, penable, pwrite, clr, lim, servo_alarm_input, emg, homing, ez} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    stp = '0;
    cyc(3);
    resetn <= 1'b1;
    rd(ADDR_ENV3, 32'h0);
    rd(8'h2C, 32'h0);
    `CHK(rerr, 1'b1)
    wr(ADDR_ENV2, 32'h0074_0000);
    rd(ADDR_ENV2, 32'h0074_0000);
    wr(ADDR_ENV2, 32'h0);
    $display("test map done");
    u_acs_axis_partner.issue(5, 1'b0, 1'b0);
    rd(ADDR_CMD_POS, 32'h5);
    rd(ADDR_DEFL, 32'h5);
    // Up/down pulse mode: phase A pulses count up, or down when inverted
    wr(ADDR_ENV2, 32'h0030_0000);
    u_acs_axis_partner.pulse_a(2);
    rd(ADDR_MECH_POS, 32'h2);
    rd(ADDR_DEFL, 32'h3);
    wr(ADDR_ENV2, 32'h0070_0000);
    u_acs_axis_partner.pulse_a(1);
    rd(ADDR_MECH_POS, 32'h1);
    // Filter rejects a one-cycle pulse
    wr(ADDR_ENV2, 32'h0074_0000);
    u_acs_axis_partner.pulse_a(1);
    rd(ADDR_MECH_POS, 32'h1);
    wr(ADDR_ENV2, 32'h0);
    wr(ADDR_COMMAND, 32'h20);
    rd(ADDR_CMD_POS, 32'h0);
    wr(ADDR_COMMAND, 32'h21);
    rd(ADDR_MECH_POS, 32'h0);
    wr(ADDR_COMMAND, 32'h22);
    rd(ADDR_DEFL, 32'h0);
    wr(ADDR_ENV3, 32'h4000_0000);
    u_acs_axis_partner.issue(4, 1'b0, 1'b0);
    rd(ADDR_DEFL, 32'h0);
    wr(ADDR_ENV3, 32'h0004_0000);
    u_acs_axis_partner.issue(2, 1'b0, 1'b0);
    rd(ADDR_DEFL, 32'h2);
    clr <= 1'b1;
    cyc(2);
    clr <= 1'b0;
    rd(ADDR_DEFL, 32'h0);
    wr(ADDR_ENV3, 32'h0040_0000);
    u_acs_axis_partner.issue(3, 1'b0, 1'b0);
    u_acs_axis_partner.issue(1, 1'b0, 1'b1);
    rd(ADDR_DEFL, 32'h0);
    wr(ADDR_COMMAND, 32'h23);
    rd(ADDR_GP, 32'h0);
    wr(ADDR_ENV3, 32'h0);
    u_acs_axis_partner.issue(3, 1'b1, 1'b0);
    rd(ADDR_GP, 32'h0);
    wr(ADDR_ENV3, 32'h0800_0000);
    u_acs_axis_partner.issue(3, 1'b1, 1'b0);
    rd(ADDR_GP, 32'h3);
    wr(ADDR_ENV3, 32'h8000_0000);
    u_acs_axis_partner.issue(2, 1'b0, 1'b0);
    rd(ADDR_GP, 32'h3);
    wr(ADDR_ENV3, 32'h0);
    $display("test counters done");
    // Level mode, active high
    wr(ADDR_ENV1, 32'h0000_F000);
    wr(ADDR_COMMAND, 32'h24);
    cyc(2);
    `CHK(dev, 1'b1)
    wr(ADDR_COMMAND, 32'h25);
    cyc(2);
    `CHK(dev, 1'b0)
    wr(ADDR_ENV1, 32'h0000_8000);
    wr(ADDR_COMMAND, 32'h24);
    cyc(DEV_PW_BASE_CYC - 1);
    `CHK(dev, 1'b1)
    cyc(2);
    `CHK(dev, 1'b0)
    wr(ADDR_ENV1, 32'h0);
    cyc(2);
    `CHK(dev, 1'b1)
    $display("test deviation clear done");
    wr(ADDR_ENV1, 32'h0000_8400);
    lim <= 1'b1;
    cyc(3);
    `CHK(pen, 1'b0)
    `CHK(dev, 1'b1)
    wr(ADDR_ENV1, 32'h0000_0008);
    cyc(3);
    `CHK(dec, 1'b1)
    lim <= 1'b0;
    $display("test limit done");
    servo_alarm_input <= 1'b1;
    emg <= 1'b1;
    stp <= '{cmp_stop: 5'h1F, bad_data: 1'b1, partner_stop: 1'b1};
    cyc(1);
    stp <= '0;
    servo_alarm_input <= 1'b0;
    emg <= 1'b0;
    u_acs_axis_partner.glitch();
    rd(ADDR_STOP_CAUSE, 32'h0001_329F);
    wr(ADDR_STOP_CAUSE, 32'hFFFF_FFFF);
    rd(ADDR_STOP_CAUSE, 32'h0);
    $display("test stop cause done");
    // Reversal waits the direction delay; a down step from zero is out of range
    wr(ADDR_COMMAND, 32'h20);
    u_acs_axis_partner.issue_dn(1);
    cyc(2);
    `CHK(pen, 1'b0)
    `CHK(mdir, 1'b1)
    rd(ADDR_STOP_CAUSE, 32'h0000_8000);
    cyc(DIR_DELAY_CYC - 16);
    `CHK(pen, 1'b0)
    cyc(16);
    `CHK(pen, 1'b1)
    wr(ADDR_ENV1, 32'h1000_0000);
    u_acs_axis_partner.issue(1, 1'b0, 1'b0);
    cyc(1);
    `CHK(pen, 1'b1)
    `CHK(mdir, 1'b0)
    $display("test direction done");
    // Z edges counted only while homing
    homing <= 1'b1;
    repeat (3) begin
      ez <= 1'b1;
      cyc(1);
      ez <= 1'b0;
      cyc(1);
    end
    rd(ADDR_SPEED_STATUS, 32'h0003_0000);
    homing <= 1'b0;
    rd(ADDR_SPEED_STATUS, 32'h0);
    $display("test zero return done");
    close_out();
  end
endmodule
